//--- dv/flash_cmd_slave_properties.sv
// Purpose: port checks for the flash command slave
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   bound into every instance of the slave
`timescale 1ns/1ps
module flash_cmd_slave_properties
    import flash_spi_pkg::*;
#(
    parameter int APB_AW = 8
) (
    // clock, reset and apb
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // serial link
    input wire logic              serial_clock,
    input wire logic              select_low,
    input wire logic              serial_out,
    input wire logic              serial_out_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    wire logic acc    = psel && penable;
    wire logic mapped = paddr == APB_AW'(OFS_CTRL) || paddr == APB_AW'(OFS_STATUS);

    ////////////////////////////////////////////////////////////////////////////////
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without slave error");
    a_err_mapped: assert property (acc && mapped |-> !pslverr)
        else $error("slave error on mapped access");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    a_stat_spare: assert property (
        psel && !penable && !pwrite && paddr == APB_AW'(OFS_STATUS) |=> prdata[31:4] == 28'h0)
        else $error("status spare bits not zero");
    a_idle_float: assert property (select_low [*6] |-> !serial_out_oe)
        else $error("output driven while deselected");
    a_oe_framed: assert property ($rose(serial_out_oe) |-> !select_low)
        else $error("output enabled outside a frame");
    a_out_on_fall: assert property (
        serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
        |-> !serial_clock || !$past(serial_clock, 2))
        else $error("output changed away from a falling link clock");
    a_oe_keep: assert property (
        serial_out_oe && !select_low && serial_clock && $past(serial_clock) |=> serial_out_oe)
        else $error("output released without a falling link clock");
endmodule // flash_cmd_slave_properties

bind flash_cmd_slave flash_cmd_slave_properties #(.APB_AW(APB_AW)) u_props (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock(serial_clock), .select_low(select_low), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe)
);

//--- dv/link_master.sv
// Purpose: link master model for the flash command slave
// Assumes: link clock idles low and stands still between frames
// Notes:   unused data line toggles, undriven bits read back unknown
`timescale 1ns/1ps
module link_master (
    // link pins
    output logic      serial_clock,
    output logic      select_low,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    localparam int HALF = 24;
    int oe_bits;

    initial begin
        serial_clock = 1'b0;
        select_low = 1'b1;
        serial_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one frame: first n bits of tx sent, m clocks in all
    task automatic frame(input logic [63:0] tx, input int n, input int m,
                         output logic [63:0] rx);
        rx = '0;
        oe_bits = 0;
        #0.5;
        select_low = 1'b0; // link edges kept off clk edges
        #(32 * HALF);
        for (int i = 0; i < m; i++) begin
            serial_in = (i < n) ? tx[63 - i] : ~serial_in;
            #HALF;
            serial_clock = 1'b1;
            rx = {rx[62:0], serial_out_oe ? serial_out : 1'bx};
            oe_bits += int'(serial_out_oe === 1'b1);
            #HALF;
            serial_clock = 1'b0;
        end
        #(3 * HALF);
        select_low = 1'b1;
        serial_in = ~serial_in;
        #(26 * HALF - 0.5);
    endtask
endmodule // link_master

//--- dv/test_spi_user_flash_command_slave.sv
// Purpose: self-checking bench for the flash command slave
// Assumes: link master model drives the serial pins
// Notes:   flash contents predicted by a behavioural model
`timescale 1ns/1ps
module test_spi_user_flash_command_slave
    import flash_spi_pkg::*;
();
    logic        clk, sys_rst, ce, psel, penable, pwrite, pready, pslverr, slverr;
    logic        serial_clock, select_low, serial_in, serial_out, serial_out_oe;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [63:0] rx;
    logic [15:0] mem [512];
    logic [15:0] rnd = 16'h000A;
    logic        wel, base;
    logic [1:0]  bp;
    int          fails, n_tests, cyc;

    flash_cmd_slave #(.APB_AW(8)) dut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_clock(serial_clock), .select_low(select_low),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    link_master lm (
        .serial_clock(serial_clock), .select_low(select_low), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic print_verdict();
        if (fails == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", s, e, g);
            fails++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) fails++;
        r = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic idle_chk();
        int k;
        k = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            k++;
        end while (r[STAT_BUSY_BIT] !== 1'b0 && k < 2000);
        chk("status", {bp, wel, 1'b0}, r[7:0]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        if (base) lm.frame({OPC_WRITE, a[7:0], d[7:0], 40'h0}, 24, 24, rx);
        else lm.frame({OPC_WRITE, a, d, 24'h0}, 40, 40, rx);
        if (wel && bp == 2'b00) begin
            if (base) mem[a[7:0]][7:0] = d[7:0];
            else mem[a[8:0]] = d;
        end
        idle_chk();
    endtask

    task automatic rd(input logic [15:0] a, input int n);
        int v;
        logic [15:0] e;
        v = (base && 256 - a[7:0] < n) ? 256 - a[7:0] : n;
        if (base) lm.frame({OPC_READ, a[7:0], 48'h0}, 16, 16 + 8 * n, rx);
        else lm.frame({OPC_READ, a, 40'h0}, 24, 24 + 16 * n, rx);
        for (int i = 0; i < v; i++) begin
            e = mem[(a[8:0] + i) % WORDS];
            if (base) chk("read_byte", e[7:0], rx[8 * (n - 1 - i) +: 8]);
            else chk("read_word", e, rx[16 * (n - 1 - i) +: 16]);
        end
        chk("out_bits", (base ? 8 : 16) * v, lm.oe_bits);
    endtask

    task automatic erase(input logic [7:0] opc, input logic [15:0] a, input logic wt);
        int lo, n;
        lo = (base || opc == OPC_FULL) ? 0 : {a[8], 8'h00};
        n = (opc == OPC_FULL && !base) ? WORDS : 256;
        if (opc == OPC_FULL || base) lm.frame({opc, 56'h0}, 8, 8, rx);
        else lm.frame({opc, a, 40'h0}, 24, 24, rx);
        if (wel && bp == 2'b00) begin
            for (int i = lo; i < lo + n; i++) mem[i] = ERASED;
        end
        if (wt) idle_chk();
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_rst, ce, psel, penable, pwrite, paddr, pwdata} = {2'b11, 3'b000, 8'h00, 32'h0};
        {wel, base, bp, fails, n_tests, cyc} = '0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        idle_chk();
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl_reset", CTRL_RESET, r);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped_err", 1'b1, slverr);
        ce <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'hC);
        ce <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ce_freeze", CTRL_RESET, r);
        apb(1'b1, OFS_STATUS, 32'hF);
        lm.frame({OPC_WL_SET, 8'hA5, 48'h0}, 16, 16, rx);
        wel = 1'b1;
        lm.frame({OPC_STAT_RD, 56'h0}, 8, 24, rx);
        chk("status_link", {2{4'h0, bp, wel, 1'b0}}, rx[15:0]);
        erase(OPC_FULL, 16'h0, 1'b1);
        for (int k = 0; k < 7; k++) begin
            rnd = lfsr(rnd);
            wr({rnd[15:9], 9'(k == 6 ? 511 : 61 * k)}, lfsr(rnd));
        end
        rd(16'h01FF, 2);
        rd(16'h003D, 1);
        lm.frame({OPC_WL_CLR, 56'h0}, 8, 8, rx);
        wel = 1'b0;
        wr(16'h0064, 16'h1234);
        lm.frame({OPC_WL_SET, 56'h0}, 8, 8, rx);
        wel = 1'b1;
        apb(1'b1, OFS_CTRL, 32'hC);
        bp = 2'b11;
        wr(16'h0065, 16'h4321);
        erase(OPC_SECT, 16'h0000, 1'b1);
        erase(OPC_FULL, 16'h0000, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h0);
        bp = 2'b00;
        rd(16'h0064, 2);
        erase(OPC_SECT, 16'hA100, 1'b1);
        rd(16'h01FF, 2);
        erase(OPC_FULL, 16'h0, 1'b0);
        lm.frame({OPC_READ, 16'h0005, 40'h0}, 24, 40, rx);
        chk("busy_read", 0, lm.oe_bits);
        erase(OPC_FULL, 16'h0, 1'b0);
        lm.frame({OPC_WRITE, 16'h0005, 16'h0000, 24'h0}, 40, 40, rx);
        idle_chk();
        rd(16'h0005, 1);
        wr(16'h012C, 16'hC0DE);
        apb(1'b1, OFS_CTRL, 32'h1);
        base = 1'b1;
        wr(16'h00FF, 16'h005A);
        wr(16'h00FE, 16'h00C3);
        rd(16'h00FE, 3);
        erase(OPC_SECT, 16'h0, 1'b1);
        rd(16'h00FE, 2);
        wr(16'h000A, 16'h0077);
        erase(OPC_FULL, 16'h0, 1'b1);
        rd(16'h0009, 2);
        apb(1'b1, OFS_CTRL, 32'h0);
        base = 1'b0;
        rd(16'h012C, 1);
        lm.frame({OPC_WL_CLR, 56'h0}, 8, 8, rx);
        wel = 1'b0;
        apb(1'b1, OFS_CTRL, 32'h2);
        lm.frame({OPC_WL_SET, 56'h0}, 8, 8, rx);
        apb(1'b1, OFS_CTRL, 32'h0);
        idle_chk();
        print_verdict();
    end
endmodule // test_spi_user_flash_command_slave

//--- rtl/flash_cmd_slave.sv
// Purpose: serial command slave giving a link master access to user flash
// Assumes: link pins are asynchronous and sampled by clk
// Notes:   control and status also visible over APB
`timescale 1ns/1ps

// Notes on behaviour
// - extended read: opcode 03 then 16 address bits, msb first
// - first seven address bits dropped, last nine form the word address
// - extended read streams words, address wraps to zero, until deselect
// - read or write opcode ignored while a program or erase runs
// - every bit on the link travels msb first
// - base read: opcode, 8-bit address, bytes increment up to 255, no wrap
// - base read: after last bit of address 255 the output floats
// - write or erase starts only after select returns high
// - extended write: opcode 02, 16-bit address, one 16-bit word
// - write needs latch set and unprotected address, else data skipped
// - base write: opcode, 8-bit address, one data byte
// - sector erase clears 256 words, needs latch and no protection
// - extended sector erase: opcode 20, address bit eight picks sector
// - base sector erase has no address and erases sector 0
// - full erase opcode 60: both sectors extended, sector 0 base
// - full erase needs latch set and no protection
// - write latch is clear after reset
// - opcode 06 sets latch, then further bits ignored until deselect
// - only the clear-latch opcode clears the latch
// - read-only configuration: no status register, latch set has no effect
// - status: busy bit 0, latch bit 1, protect bits 3:2, reset zero
// - protect bits zero: unprotected; any bit set: whole array protected
// - sample on rising link clock, drive on falling, float when deselected
module flash_cmd_slave
    import flash_spi_pkg::*;
#(
    parameter int APB_AW = 8
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // serial link
    input  wire logic              serial_clock,
    input  wire logic              select_low,
    input  wire logic              serial_in,
    output logic                   serial_out,
    output logic                   serial_out_oe
);

    initial begin
        if (APB_AW < 8) begin
            $error("APB_AW must be at least 8");
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] sck_sy;
    logic [2:0] cs_sy;
    logic [2:0] si_sy;
    logic       sck_f;
    logic       cs_f;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_sy <= 3'h0;
            cs_sy  <= 3'h7;
            si_sy  <= 3'h0;
        end else if (ce) begin
            sck_sy <= {sck_sy[1:0], serial_clock};
            cs_sy  <= {cs_sy[1:0], select_low};
            si_sy  <= {si_sy[1:0], serial_in};
        end
    end

    wire sck_ok    = sck_sy[1] == sck_sy[2];
    wire cs_ok     = cs_sy[1] == cs_sy[2];
    wire sck_rise  = sck_ok && sck_sy[2] && !sck_f;
    wire sck_fall  = sck_ok && !sck_sy[2] && sck_f;
    wire cs_fall   = cs_ok && !cs_sy[2] && cs_f;
    wire cs_rise   = cs_ok && cs_sy[2] && !cs_f;
    wire si_bit    = si_sy[2];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_f <= 1'b0;
            cs_f  <= 1'b1;
        end else if (ce) begin
            if (sck_ok) begin
                sck_f <= sck_sy[2];
            end
            if (cs_ok) begin
                cs_f <= cs_sy[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control and status
    ctrl_s       ctrl;
    logic        wel;
    logic        busy;
    status_s     stat;
    logic [15:0] mem [WORDS];

    wire base      = ctrl.base_mode;
    wire ro        = ctrl.read_only;
    wire prot      = ctrl.bp != 2'b00;
    wire allow     = wel && !prot && !ro;
    wire [4:0] alen = base ? LEN_BASE : LEN_EXT;
    wire [4:0] dlen = base ? LEN_BASE : LEN_EXT;

    assign stat = '{spare: 4'h0, bp: ctrl.bp, wel: wel, busy: busy};

    ////////////////////////////////////////////////////////////////////
    // apb slave
    wire apb_setup = psel && !penable;
    wire hit_ctrl  = paddr == APB_AW'(OFS_CTRL);
    wire hit_stat  = paddr == APB_AW'(OFS_STATUS);
    wire apb_hit   = hit_ctrl || hit_stat;
    wire apb_wr    = psel && penable && pwrite && hit_ctrl && !busy;

    wire [31:0] rd_mux = hit_ctrl ? {28'h0, ctrl} :
                         hit_stat ? {24'h0, stat} : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !apb_hit;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0;
            ctrl   <= CTRL_RESET;
        end else if (ce) begin
            if (apb_setup && !pwrite) begin
                prdata <= rd_mux;
            end
            if (apb_wr) begin
                ctrl <= pwdata[3:0];                       // bp frozen while busy
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link command engine
    link_state_e state;
    logic [7:0]  opc;
    logic [15:0] shin;
    logic [4:0]  cnt;
    logic [4:0]  ocnt;
    logic [15:0] tx;
    logic [8:0]  ptr;
    logic        done;
    logic        pend;
    logic        pend_wr;
    logic [8:0]  pend_lo;
    logic [8:0]  pend_hi;
    logic [15:0] pend_val;

    wire [15:0] shv     = {shin[14:0], si_bit};
    wire        last_in = cnt == alen - 5'h1;
    wire        last_dt = cnt == dlen - 5'h1;
    wire        last_op = cnt == LEN_OPC - 5'h1;
    wire [8:0]  a_word  = base ? {1'b0, shv[7:0]} : shv[8:0];
    wire [8:0]  nxt_ptr = ptr + 9'h1;
    wire        top     = base && ptr[7:0] == BASE_TOP;
    wire [15:0] w_at_a  = base ? {mem[a_word][7:0], 8'h00} : mem[a_word];
    wire [15:0] w_nxt   = base ? {mem[nxt_ptr][7:0], 8'h00} : mem[nxt_ptr];
    wire [15:0] sr_word = {stat, 8'h00};
    wire [8:0]  sect_lo = (!base && shv[8]) ? SECT1_LO : 9'h000;
    wire        is_wr   = opc == OPC_WRITE;
    wire        is_rd   = opc == OPC_READ;
    wire [4:0]  out_len = (state == ST_SR) ? LEN_OPC : dlen; // status is one byte

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= ST_IDLE;
            opc      <= 8'h00;
            shin     <= 16'h0;
            cnt      <= 5'h0;
            ocnt     <= 5'h0;
            tx       <= 16'h0;
            ptr      <= 9'h0;
            done     <= 1'b0;
            wel      <= 1'b0;
            pend     <= 1'b0;
            pend_wr  <= 1'b0;
            pend_lo  <= 9'h0;
            pend_hi  <= 9'h0;
            pend_val <= 16'h0;
            serial_out <= 1'b0;
        end else if (ce) begin
            if (cs_fall) begin
                state <= ST_OPC;
                cnt   <= 5'h0;
                ocnt  <= 5'h0;
                done  <= 1'b0;
                pend  <= 1'b0;
            end else if (cs_rise) begin
                state <= ST_IDLE;
                pend  <= 1'b0;
            end else if (!cs_f && sck_rise) begin
                shin <= shv;
                cnt  <= cnt + 5'h1;
                case (state)
                    ST_OPC: begin
                        if (last_op) begin
                            opc   <= shv[7:0];
                            cnt   <= 5'h0;
                            state <= ST_WAIT;
                            case (shv[7:0])
                                OPC_READ: begin
                                    if (!busy) begin
                                        state <= ST_ADDR;
                                    end
                                end
                                OPC_WRITE: begin
                                    if (!busy) begin
                                        state <= ST_ADDR;
                                    end
                                end
                                OPC_SECT: begin
                                    if (!busy && !base) begin
                                        state <= ST_ADDR;
                                    end else if (!busy && allow) begin
                                        pend    <= 1'b1;
                                        pend_wr <= 1'b0;
                                        pend_lo <= 9'h000;
                                        pend_hi <= SECT_LAST;
                                    end
                                end
                                OPC_FULL: begin
                                    if (!busy && allow) begin
                                        pend    <= 1'b1;
                                        pend_wr <= 1'b0;
                                        pend_lo <= 9'h000;
                                        pend_hi <= base ? SECT_LAST : ARR_LAST;
                                    end
                                end
                                OPC_WL_SET: begin
                                    if (!busy && !ro) begin
                                        wel <= 1'b1;
                                    end
                                end
                                OPC_WL_CLR: begin
                                    if (!busy && !ro) begin
                                        wel <= 1'b0;
                                    end
                                end
                                OPC_STAT_RD: begin
                                    if (!ro) begin
                                        state <= ST_SR;
                                        tx    <= sr_word;
                                    end
                                end
                                default: begin
                                    state <= ST_WAIT;
                                end
                            endcase
                        end
                    end
                    ST_ADDR: begin
                        if (last_in) begin
                            cnt   <= 5'h0;
                            state <= ST_WAIT;
                            if (is_rd) begin
                                state <= ST_RD;
                                ptr   <= a_word;
                                tx    <= w_at_a;
                            end else if (is_wr && allow) begin
                                state   <= ST_WDATA;
                                pend_lo <= a_word;
                                pend_hi <= a_word;
                            end else if (!is_wr && allow) begin
                                pend    <= 1'b1;
                                pend_wr <= 1'b0;
                                pend_lo <= sect_lo;
                                pend_hi <= sect_lo + SECT_LAST;
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (last_dt) begin
                            state    <= ST_WAIT;
                            pend     <= 1'b1;
                            pend_wr  <= 1'b1;
                            pend_val <= base ? {mem[pend_lo][15:8], shv[7:0]} : shv;
                        end
                    end
                    default: begin
                        cnt <= cnt;
                    end
                endcase
            end else if (!cs_f && sck_fall) begin
                if ((state == ST_RD && !done) || state == ST_SR) begin
                    serial_out <= tx[15];
                    tx         <= {tx[14:0], 1'b0};
                    ocnt       <= ocnt + 5'h1;
                    if (ocnt == out_len - 5'h1) begin
                        ocnt <= 5'h0;
                        if (state == ST_SR) begin
                            tx <= sr_word;
                        end else if (top) begin
                            done <= 1'b1;
                            ocnt <= dlen;              // last bit held to next fall
                        end else begin
                            ptr <= nxt_ptr;
                            tx  <= w_nxt;
                        end
                    end
                end else if (state == ST_RD) begin
                    ocnt <= 5'h0;                      // float after last byte
                end
            end
        end
    end

    // floats once base read passes 255 and whenever deselected
    assign serial_out_oe = !cs_f && (state == ST_SR ||
                           (state == ST_RD && ocnt != 5'h0) ||
                           (state == ST_RD && !done)) &&
                           !(done && ocnt == 5'h0);

    ////////////////////////////////////////////////////////////////////
    // self-timed program and erase
    logic [8:0]  eptr;
    logic [8:0]  eend;
    logic        ewr;
    logic [15:0] eval;

    wire launch = cs_rise && pend && !busy;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b0;
            eptr <= 9'h0;
            eend <= 9'h0;
            ewr  <= 1'b0;
            eval <= 16'h0;
        end else if (ce) begin
            if (launch) begin
                busy <= 1'b1;
                eptr <= pend_lo;
                eend <= pend_hi;
                ewr  <= pend_wr;
                eval <= pend_val;
            end else if (busy) begin
                eptr <= eptr + 9'h1;
                if (eptr == eend) begin
                    busy <= 1'b0;
                end
            end
        end
    end

    // latch left untouched on completion
    always_ff @(posedge clk) begin
        if (ce && busy) begin
            mem[eptr] <= ewr ? eval : ERASED;
        end
    end

endmodule // flash_cmd_slave

//--- shared/flash_spi_pkg.sv
// Purpose: constants and types shared by the flash command slave
// Assumes: 32-bit APB, one register per aligned word
// Notes:   opcodes are sent msb first on the serial link
package flash_spi_pkg;

    // opcodes
    localparam logic [7:0] OPC_READ     = 8'h03;
    localparam logic [7:0] OPC_WRITE    = 8'h02;
    localparam logic [7:0] OPC_SECT     = 8'h20;
    localparam logic [7:0] OPC_FULL     = 8'h60;
    localparam logic [7:0] OPC_WL_SET   = 8'h06;
    localparam logic [7:0] OPC_WL_CLR   = 8'h04;
    localparam logic [7:0] OPC_STAT_RD  = 8'h05;

    // register offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;

    // control fields
    localparam int CTRL_BASE_BIT        = 0;
    localparam int CTRL_RO_BIT          = 1;
    localparam int CTRL_BP_LO           = 2;
    localparam logic [3:0] CTRL_RESET   = 4'h0;

    // status fields
    localparam int STAT_BUSY_BIT        = 0;
    localparam int STAT_WEL_BIT         = 1;
    localparam int STAT_BP_LO           = 2;

    // geometry
    localparam int            WORD_AW   = 9;
    localparam int            WORDS     = 512;
    localparam logic [8:0]    SECT_LAST = 9'h0FF;
    localparam logic [8:0]    ARR_LAST  = 9'h1FF;
    localparam logic [8:0]    SECT1_LO  = 9'h100;
    localparam logic [7:0]    BASE_TOP  = 8'hFF;
    localparam logic [15:0]   ERASED    = 16'hFFFF;
    localparam logic [4:0]    LEN_EXT   = 5'h10;
    localparam logic [4:0]    LEN_BASE  = 5'h08;
    localparam logic [4:0]    LEN_OPC   = 5'h08;

    typedef struct packed {
        logic [1:0] bp;
        logic       read_only;
        logic       base_mode;
    } ctrl_s;

    typedef struct packed {
        logic [3:0] spare;
        logic [1:0] bp;
        logic       wel;
        logic       busy;
    } status_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_OPC   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_WDATA = 3'b011,
        ST_RD    = 3'b100,
        ST_SR    = 3'b101,
        ST_WAIT  = 3'b110
    } link_state_e;

endpackage
